// *** rtl/rhwc_consts.svh ***
// constants for the radio host wake cause block
`ifndef RHWC_CONSTS_SVH
`define RHWC_CONSTS_SVH

// pin output-select values
`define RHWC_SEL_HOST_WAKE 6'h14
`define RHWC_SEL_LBT_PAIR 6'h0F
`define RHWC_SEL_W 6

// wake cause codes
`define RHWC_CAUSE_NO_FAILURE 8'h00
`define RHWC_CAUSE_RX_TIMEOUT 8'h01
`define RHWC_CAUSE_RX_TERM 8'h02
`define RHWC_CAUSE_SYNC_LOST 8'h03
`define RHWC_CAUSE_DROP_LEN 8'h04
`define RHWC_CAUSE_DROP_ADDR 8'h05
`define RHWC_CAUSE_DROP_CRC 8'h06
`define RHWC_CAUSE_TXF_OVF 8'h07
`define RHWC_CAUSE_TXF_UNF 8'h08
`define RHWC_CAUSE_RXF_OVF 8'h09
`define RHWC_CAUSE_RXF_UNF 8'h0A
`define RHWC_CAUSE_CCA_FAIL 8'h0B
`define RHWC_CAUSE_TX_DONE 8'h40
`define RHWC_CAUSE_RX_DONE 8'h80
`define RHWC_CAUSE_RESET 8'h00

// wake-on-radio mode field values
`define RHWC_WOR_FEEDBACK 3'h0
`define RHWC_WOR_NORMAL 3'h1

// consecutive missed slots before sync is declared lost
`define RHWC_SYNC_LOST_SLOTS 5'h10

// failed flag position inside status register zero
`define RHWC_STAT0_LBT_FAILED_BIT 0

`endif

// *** rtl/rhwc_pin_mux.sv ***
// general-purpose output pin selector for wake and listen-before-talk signals
`timescale 1ns/1ps
`default_nettype none
`include "rhwc_consts.svh"
module rhwc_pin_mux #(
  parameter int NUM_PINS = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [NUM_PINS*`RHWC_SEL_W-1:0] pin_output_select, // per-pin select
  input wire logic wake, // wake pulse source
  input wire logic lbt_done, // listen-before-talk done
  input wire logic lbt_failed, // listen-before-talk failed
  output logic [NUM_PINS-1:0] pin_out // registered pin levels
);
  typedef struct packed {
    logic [NUM_PINS-1:0] pins;
  } rhwc_mux_t;

  rhwc_mux_t q;
  rhwc_mux_t d;

  always_comb begin
    d = q;
    for (int i = 0; i < NUM_PINS; i++) begin
      unique case (pin_output_select[i*`RHWC_SEL_W +: `RHWC_SEL_W])
        `RHWC_SEL_HOST_WAKE: d.pins[i] = wake;
        // pin 0 carries failed, every other pin carries done
        `RHWC_SEL_LBT_PAIR: d.pins[i] = (i == 0) ? lbt_failed : lbt_done;
        default: d.pins[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_out = q.pins;
endmodule // rhwc_pin_mux
`default_nettype wire

// *** rtl/rhwc_pkg.sv ***
// types for the radio host wake cause block
package rhwc_pkg;

  typedef logic [7:0] rhwc_cause_t;

  typedef logic [2:0] rhwc_wor_mode_t;

  typedef enum logic [1:0] {
    RHWC_ST_RESET = 2'h0,
    RHWC_ST_ACTIVE = 2'h1,
    RHWC_ST_IDLE = 2'h3
  } rhwc_state_t;

  // qualified one-cycle events from the radio controller
  typedef struct packed {
    logic txf_ovf;
    logic txf_unf;
    logic rxf_ovf;
    logic rxf_unf;
    logic cca_fail;
    logic sync_lost;
    logic drop_len;
    logic drop_addr;
    logic drop_crc;
    logic rx_timeout;
    logic rx_term;
    logic rx_done;
    logic tx_done;
    logic cal_end;
  } rhwc_evt_t;

  typedef struct packed {
    rhwc_state_t st;
    logic pend_vld;
    rhwc_cause_t pend_code;
    logic wake;
    rhwc_cause_t code;
    logic fresh;
    logic overrun;
    logic sleep;
    logic lbt_done;
    logic lbt_failed;
    logic [4:0] slot_cnt;
  } rhwc_core_t;

endpackage

// *** rtl/rhwc_wake_cause.sv ***
// host wake pulse and wake cause logic of the radio controller
`timescale 1ns/1ps
`default_nettype none
`include "rhwc_consts.svh"
module rhwc_wake_cause #(
  parameter int NUM_PINS = 4
) (
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic radio_idle, // radio controller is in idle
  input wire logic rx_mode, // radio is receiving
  input wire logic enhanced_wake_on_radio, // enhanced wake-on-radio in use
  input wire rhwc_pkg::rhwc_wor_mode_t wake_on_radio_mode_sel, // wake-on-radio mode
  input wire logic terminate_on_bad_packet, // end receive on bad packet
  input wire logic calibration_end_wake_enable, // wake after calibration
  input wire logic [NUM_PINS*`RHWC_SEL_W-1:0] pin_output_select, // per-pin select
  input wire logic ev_rx_timeout, // receive timeout pulse
  input wire logic ev_rx_term, // carrier sense or preamble quality termination
  input wire logic ev_slot_ok, // wake-on-radio slot with good reception
  input wire logic ev_slot_miss, // wake-on-radio slot without reception
  input wire logic ev_drop_len, // packet dropped by length filter
  input wire logic ev_drop_addr, // packet dropped by address filter
  input wire logic ev_drop_crc, // packet dropped by checksum filter
  input wire logic ev_txf_ovf, // transmit FIFO overflow
  input wire logic ev_txf_unf, // transmit FIFO underflow
  input wire logic ev_rxf_ovf, // receive FIFO overflow
  input wire logic ev_rxf_unf, // receive FIFO underflow
  input wire logic ev_tx_strobe, // new transmit strobe
  input wire logic ev_cca_busy, // transmit strobe refused, channel busy
  input wire logic ev_cca_clear, // channel clear, transmit goes ahead
  input wire logic ev_tx_done, // transmission finished
  input wire logic ev_rx_done, // reception finished, packet in FIFO
  input wire logic ev_cal_end, // calibration finished
  input wire logic host_read_ack, // host has read the cause code
  output logic host_wake_pulse, // one-cycle wake pulse
  output rhwc_pkg::rhwc_cause_t wake_cause_code, // last cause code
  output logic [7:0] radio_ctrl_status_zero, // status register zero
  output logic listen_before_talk_done, // clear channel check done
  output logic listen_before_talk_failed, // clear channel check failed
  output logic sleep_until_next_slot, // discard pulse in wake-on-radio
  output logic cause_fresh, // cause not yet acknowledged
  output logic cause_overrun, // a pending cause was replaced
  output logic [NUM_PINS-1:0] gpio_out // general-purpose output pins
);
  import rhwc_pkg::*;

  rhwc_core_t q;
  rhwc_core_t d;
  rhwc_evt_t evt;
  logic [8:0] pick;
  logic enhanced_wake_on_radio_slotted;
  logic enhanced_wake_on_radio_feedback;
  logic bad_pkt_rx;

  // fixed priority among events of one cycle: valid bit over code
  function automatic logic [8:0] pick_cause(input rhwc_evt_t e);
    logic [8:0] r;
    r = {1'b0, `RHWC_CAUSE_NO_FAILURE};
    if (e.cal_end) r = {1'b1, `RHWC_CAUSE_NO_FAILURE};
    if (e.tx_done) r = {1'b1, `RHWC_CAUSE_TX_DONE};
    if (e.rx_done) r = {1'b1, `RHWC_CAUSE_RX_DONE};
    if (e.rx_term) r = {1'b1, `RHWC_CAUSE_RX_TERM};
    if (e.rx_timeout) r = {1'b1, `RHWC_CAUSE_RX_TIMEOUT};
    if (e.drop_crc) r = {1'b1, `RHWC_CAUSE_DROP_CRC};
    if (e.drop_addr) r = {1'b1, `RHWC_CAUSE_DROP_ADDR};
    if (e.drop_len) r = {1'b1, `RHWC_CAUSE_DROP_LEN};
    if (e.sync_lost) r = {1'b1, `RHWC_CAUSE_SYNC_LOST};
    if (e.cca_fail) r = {1'b1, `RHWC_CAUSE_CCA_FAIL};
    if (e.rxf_unf) r = {1'b1, `RHWC_CAUSE_RXF_UNF};
    if (e.rxf_ovf) r = {1'b1, `RHWC_CAUSE_RXF_OVF};
    if (e.txf_unf) r = {1'b1, `RHWC_CAUSE_TXF_UNF};
    if (e.txf_ovf) r = {1'b1, `RHWC_CAUSE_TXF_OVF};
    return r;
  endfunction

  always_comb begin
    d = q;
    d.wake = 1'b0;
    d.sleep = 1'b0;
    evt = '0;
    enhanced_wake_on_radio_feedback = enhanced_wake_on_radio &&
                    (wake_on_radio_mode_sel == `RHWC_WOR_FEEDBACK);
    enhanced_wake_on_radio_slotted = enhanced_wake_on_radio_feedback ||
                   (enhanced_wake_on_radio &&
                    (wake_on_radio_mode_sel == `RHWC_WOR_NORMAL));
    bad_pkt_rx = rx_mode && terminate_on_bad_packet;

    // consecutive missed slots, only counted in feedback mode
    if (!enhanced_wake_on_radio_feedback || ev_slot_ok) begin
      d.slot_cnt = 5'h00;
    end else if (ev_slot_miss) begin
      if (q.slot_cnt == `RHWC_SYNC_LOST_SLOTS - 5'h01) begin
        d.slot_cnt = 5'h00;
        evt.sync_lost = 1'b1;
      end else begin
        d.slot_cnt = q.slot_cnt + 5'h01;
      end
    end

    // discards wake only outside slotted wake-on-radio
    if (bad_pkt_rx && !enhanced_wake_on_radio_slotted) begin
      evt.drop_len = ev_drop_len;
      evt.drop_addr = ev_drop_addr;
      evt.drop_crc = ev_drop_crc;
    end
    if (enhanced_wake_on_radio_slotted && (ev_drop_len || ev_drop_addr || ev_drop_crc)) begin
      d.sleep = 1'b1;
    end

    evt.rx_timeout = ev_rx_timeout && rx_mode && !enhanced_wake_on_radio;
    evt.rx_term = ev_rx_term && rx_mode && !enhanced_wake_on_radio;
    evt.txf_ovf = ev_txf_ovf;
    evt.txf_unf = ev_txf_unf;
    evt.rxf_ovf = ev_rxf_ovf;
    evt.rxf_unf = ev_rxf_unf;
    evt.cca_fail = ev_cca_busy;
    evt.tx_done = ev_tx_done;
    evt.rx_done = ev_rx_done;
    evt.cal_end = ev_cal_end && calibration_end_wake_enable;

    // listen-before-talk flags: a busy result wins over a same-cycle strobe
    if (ev_tx_strobe) begin
      d.lbt_done = 1'b0;
      d.lbt_failed = 1'b0;
    end
    if (ev_cca_clear) begin
      d.lbt_done = 1'b1;
      d.lbt_failed = 1'b0;
    end
    if (ev_cca_busy) begin
      d.lbt_done = 1'b1;
      d.lbt_failed = 1'b1;
    end

    // host acknowledge clears first so that a new wake still sets
    if (host_read_ack) begin
      d.fresh = 1'b0;
      d.overrun = 1'b0;
    end

    // newest cause replaces any older one still waiting for idle
    pick = pick_cause(evt);
    if (pick[8]) begin
      if (q.pend_vld) begin
        d.overrun = 1'b1;
      end
      d.pend_vld = 1'b1;
      d.pend_code = pick[7:0];
    end

    unique case (q.st)
      RHWC_ST_RESET: begin
        d.st = radio_idle ? RHWC_ST_IDLE : RHWC_ST_ACTIVE;
      end
      RHWC_ST_ACTIVE: begin
        if (radio_idle) begin
          d.st = RHWC_ST_IDLE;
          if (d.pend_vld) begin
            d.wake = 1'b1;
            d.code = d.pend_code;
            d.pend_vld = 1'b0;
            d.fresh = 1'b1;
          end
        end
      end
      RHWC_ST_IDLE: begin
        if (!radio_idle) begin
          d.st = RHWC_ST_ACTIVE;
        end
      end
      default: begin
        d.st = RHWC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: RHWC_ST_RESET, pend_code: `RHWC_CAUSE_RESET,
             code: `RHWC_CAUSE_RESET, default: '0};
    end else begin
      q <= d;
    end
  end

  rhwc_pin_mux #(
    .NUM_PINS(NUM_PINS)
  ) u_pin_mux (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_output_select(pin_output_select),
    .wake(d.wake),
    .lbt_done(d.lbt_done),
    .lbt_failed(d.lbt_failed),
    .pin_out(gpio_out)
  );

  assign host_wake_pulse = q.wake;
  assign wake_cause_code = q.code;
  always_comb begin
    radio_ctrl_status_zero = 8'h00;
    radio_ctrl_status_zero[`RHWC_STAT0_LBT_FAILED_BIT] = q.lbt_failed;
  end
  assign listen_before_talk_done = q.lbt_done;
  assign listen_before_talk_failed = q.lbt_failed;
  assign sleep_until_next_slot = q.sleep;
  assign cause_fresh = q.fresh;
  assign cause_overrun = q.overrun;
endmodule // rhwc_wake_cause
`default_nettype wire

// *** sim/rhwc_host_model.sv ***
// host model: acknowledges every wake pulse and reads the cause
`timescale 1ns/1ps
`default_nettype none
module rhwc_host_model (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic host_wake_pulse, // wake line from the radio
  input wire rhwc_pkg::rhwc_cause_t wake_cause_code, // cause code
  output logic host_read_ack, // cause has been read
  output rhwc_pkg::rhwc_cause_t last_cause, // cause read at the last wake
  output logic flush_req // host wants a fifo flush
);
  import rhwc_pkg::*;
  // reacts half a cycle after the wake edge, as a real host reacts late
  always @(negedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      host_read_ack <= 1'b0;
      last_cause <= 8'h00;
      flush_req <= 1'b0;
    end else begin
      host_read_ack <= host_wake_pulse;
      if (host_wake_pulse) begin
        last_cause <= wake_cause_code;
        flush_req <= wake_cause_code inside {[8'h07:8'h0A]};
      end
    end
  end
endmodule // rhwc_host_model
`default_nettype wire

// *** sim/rhwc_wake_cause_monitor.sv ***
// assertions on the ports of the wake cause block
`timescale 1ns/1ps
`default_nettype none
module rhwc_wake_cause_monitor #(
  parameter int NUM_PINS = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic radio_idle, // idle level
  input wire logic enhanced_wake_on_radio, // enhanced mode
  input wire rhwc_pkg::rhwc_wor_mode_t wake_on_radio_mode_sel, // mode
  input wire logic [NUM_PINS*6-1:0] pin_output_select, // pin selects
  input wire logic ev_drop_len, // length drop
  input wire logic ev_cca_busy, // busy channel
  input wire logic ev_tx_strobe, // transmit strobe
  input wire logic host_wake_pulse, // wake pulse
  input wire rhwc_pkg::rhwc_cause_t wake_cause_code, // cause
  input wire logic [7:0] radio_ctrl_status_zero, // status zero
  input wire logic listen_before_talk_done, // done flag
  input wire logic listen_before_talk_failed, // failed flag
  input wire logic sleep_until_next_slot, // sleep pulse
  input wire logic [NUM_PINS-1:0] gpio_out // pins
);
  import rhwc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wake_on_idle_a:
    assert property (host_wake_pulse |-> $past(radio_idle) && !$past(radio_idle, 2))
    else $error("wake pulse without idle entry");
  cause_stable_a:
    assert property (!host_wake_pulse |-> $stable(wake_cause_code))
    else $error("cause code moved without wake");
  wake_pin_a:
    assert property ($stable(pin_output_select) && pin_output_select[5:0] == 6'h14
      |-> gpio_out[0] == host_wake_pulse) else $error("wake pin mismatch");
  lbt_pin_a:
    assert property ($stable(pin_output_select) && pin_output_select[11:6] == 6'h0F
      |-> gpio_out[1] == listen_before_talk_done) else $error("done pin mismatch");
  cca_fail_a:
    assert property (ev_cca_busy |=> listen_before_talk_done && listen_before_talk_failed)
    else $error("busy channel flags missing");
  strobe_clear_a:
    assert property (ev_tx_strobe && !ev_cca_busy |=> !listen_before_talk_failed)
    else $error("strobe left failed flag");
  fail_mirror_a:
    assert property (radio_ctrl_status_zero == {7'h00, listen_before_talk_failed})
    else $error("status zero mismatch");
  drop_sleep_a:
    assert property (enhanced_wake_on_radio && wake_on_radio_mode_sel < 3'h2 && ev_drop_len
      |-> ##[1:2] sleep_until_next_slot) else $error("no sleep after drop");
  cover property (host_wake_pulse && wake_cause_code == 8'h03);
  cover property (sleep_until_next_slot);
  cover property (ev_cca_busy ##1 listen_before_talk_failed);
endmodule // rhwc_wake_cause_monitor
bind rhwc_wake_cause rhwc_wake_cause_monitor #(.NUM_PINS(NUM_PINS)) mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .radio_idle(radio_idle),
  .enhanced_wake_on_radio(enhanced_wake_on_radio), .wake_on_radio_mode_sel(wake_on_radio_mode_sel),
  .pin_output_select(pin_output_select), .ev_drop_len(ev_drop_len), .ev_cca_busy(ev_cca_busy),
  .ev_tx_strobe(ev_tx_strobe), .host_wake_pulse(host_wake_pulse),
  .wake_cause_code(wake_cause_code), .radio_ctrl_status_zero(radio_ctrl_status_zero),
  .listen_before_talk_done(listen_before_talk_done),
  .listen_before_talk_failed(listen_before_talk_failed),
  .sleep_until_next_slot(sleep_until_next_slot), .gpio_out(gpio_out));
`default_nettype wire

// *** sim/rhwc_wake_cause_test.sv ***
// self-checking testbench of the wake cause block
`timescale 1ns/1ps
`default_nettype none
module rhwc_wake_cause_test;
  import rhwc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic radio_idle = 1'b1;
  logic rx_mode = 1'b1;
  logic enh = 1'b0;
  logic term = 1'b1;
  logic cal_en = 1'b1;
  rhwc_wor_mode_t mode = 3'h3;
  logic [16:0] ev = 17'h0;
  logic ack, wk, slp, done, failed, fresh, ovr, flush;
  rhwc_cause_t code, seen;
  logic [7:0] st0;
  logic [3:0] gpio;
  int fail_count = 0;
  int n_compared = 0;
  always #25 clk_sys = ~clk_sys;
  rhwc_wake_cause #(.NUM_PINS(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .radio_idle(radio_idle),
    .rx_mode(rx_mode), .enhanced_wake_on_radio(enh), .wake_on_radio_mode_sel(mode),
    .terminate_on_bad_packet(term), .calibration_end_wake_enable(cal_en),
    .pin_output_select({6'h00, 6'h00, 6'h0F, 6'h14}), .ev_rx_timeout(ev[0]), .ev_rx_term(ev[1]),
    .ev_slot_ok(ev[2]), .ev_slot_miss(ev[3]), .ev_drop_len(ev[4]), .ev_drop_addr(ev[5]),
    .ev_drop_crc(ev[6]), .ev_txf_ovf(ev[7]), .ev_txf_unf(ev[8]), .ev_rxf_ovf(ev[9]),
    .ev_rxf_unf(ev[10]), .ev_cca_clear(ev[11]), .ev_cca_busy(ev[12]), .ev_tx_strobe(ev[13]),
    .ev_tx_done(ev[14]), .ev_rx_done(ev[15]), .ev_cal_end(ev[16]), .host_read_ack(ack),
    .host_wake_pulse(wk), .wake_cause_code(code), .radio_ctrl_status_zero(st0),
    .listen_before_talk_done(done), .listen_before_talk_failed(failed),
    .sleep_until_next_slot(slp), .cause_fresh(fresh), .cause_overrun(ovr), .gpio_out(gpio));
  rhwc_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .host_wake_pulse(wk),
    .wake_cause_code(code), .host_read_ack(ack), .last_cause(seen), .flush_req(flush));
  task automatic cmp(input logic [7:0] a, input logic [7:0] e);
    n_compared++;
    if (a !== e) begin
      fail_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // event held n cycles while active, then idle entry; collects wake and sleep
  task automatic run(input int b, input int n, output logic w, output logic s);
    @(negedge clk_sys);
    radio_idle = 1'b0;
    ev[b] = 1'b1;
    repeat (n) @(negedge clk_sys);
    w = wk;
    s = slp;
    ev = 17'h0;
    radio_idle = 1'b1;
    repeat (4) begin
      @(negedge clk_sys);
      w = w | wk;
      s = s | slp;
    end
  endtask
  task automatic t_causes();
    int idx[13] = '{0, 1, 4, 5, 6, 7, 8, 9, 10, 12, 14, 15, 16};
    logic [7:0] exp[13] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
      8'h0B, 8'h40, 8'h80, 8'h00};
    logic w, s;
    for (int i = 0; i < 13; i++) begin
      run(idx[i], 1, w, s);
      cmp({7'h00, w}, 8'h01);
      cmp(code, exp[i]);
      cmp(seen, exp[i]);
      cmp({7'h00, flush}, {7'h00, exp[i] inside {[8'h07:8'h0A]}});
      cmp({6'h00, ovr, fresh}, 8'h00);
    end
    cmp({6'h00, done, failed}, 8'h03);
    cmp(st0, 8'h01);
  endtask
  task automatic t_lbt();
    logic w, s;
    run(13, 1, w, s);
    cmp({5'h00, w, done, failed}, 8'h00);
    run(11, 1, w, s);
    cmp({5'h00, w, done, failed}, 8'h02);
  endtask
  task automatic t_sync();
    logic w, s;
    mode = 3'h0;
    enh = 1'b1;
    run(2, 1, w, s);
    run(3, 15, w, s);
    cmp({7'h00, w}, 8'h00);
    run(3, 1, w, s);
    cmp({6'h00, w, s}, 8'h02);
    cmp(code, 8'h03);
    run(5, 1, w, s);
    cmp({6'h00, w, s}, 8'h01);
  endtask
  task automatic t_refuse();
    logic w, s;
    mode = 3'h3;
    run(0, 1, w, s);
    cmp({7'h00, w}, 8'h00);
    enh = 1'b0;
    rx_mode = 1'b0;
    run(0, 1, w, s);
    cmp({7'h00, w}, 8'h00);
    rx_mode = 1'b1;
    cal_en = 1'b0;
    run(16, 1, w, s);
    cmp({7'h00, w}, 8'h00);
    term = 1'b0;
    run(4, 1, w, s);
    cmp({7'h00, w}, 8'h00);
    cmp(code, 8'h03);
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    cmp(code, 8'h00);
    t_causes();
    t_lbt();
    t_sync();
    t_refuse();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end
endmodule // rhwc_wake_cause_test
`default_nettype wire
